// ### hdl/thi_map.svh
`ifndef THI_MAP_SVH
`define THI_MAP_SVH
// ****************************************
// Register pages (paddr[15:8]), header nibble (paddr[15:12]) and offsets
// ****************************************
`define THI_MI_PAGE 8'h00
`define THI_BOP_PAGE 8'h01
`define THI_L2T_PAGE 8'h02
`define THI_L3T_PAGE 8'h03
`define THI_REG_PAGE 8'h04
`define THI_HDR_NIB 4'h1
`define THI_CTRL_OFS 8'h00
`define THI_STAT_OFS 8'h04
// ****************************************
// Reset values
// ****************************************
`define THI_CTRL_RST 1'b1
// ****************************************
// Protocol sizes and codes
// ****************************************
`define THI_MAX_HDR 7'd64
`define THI_ETH_L2_LEN 16'd12
`define THI_VLAN_LEN 16'd4
`define THI_ETYPE_LEN 16'd2
`define THI_MAX_VLANS 2'd2
`define THI_TPID_C 16'h8100
`define THI_TPID_S 16'h88a8
`define THI_ETYPE_IPV4 16'h0800
`define THI_ETYPE_IPV6 16'h86dd
`define THI_IPV4_HLEN 16'd20
`define THI_IPV6_HLEN 16'd40
`define THI_L2_IP_OFS 6'd2
`define THI_V4_LEN_OFS 16'd2
`define THI_V4_W8_OFS 16'd8
`define THI_V4_PROTO_OFS 16'd9
`define THI_V4_CSUM_OFS 16'd10
`define THI_V6_LEN_OFS 16'd4
`define THI_V6_NH_OFS 16'd6
`endif

// ### hdl/thi_pkg.sv
package thi_pkg;
   typedef enum logic [1:0] {
      THI_POS_BEGIN = 2'h0,
      THI_POS_AFTER_L2 = 2'h1,
      THI_POS_AFTER_L3 = 2'h2,
      THI_POS_RSV = 2'h3
   } thi_pos_t;
   typedef enum logic [1:0] {
      THI_IP_NONE = 2'h0,
      THI_IP_V4 = 2'h1,
      THI_IP_V6 = 2'h2,
      THI_IP_RSV = 2'h3
   } thi_ipsel_t;
   typedef enum logic [3:0] {
      THI_ST_IDLE = 4'b0001,
      THI_ST_PRE = 4'b0010,
      THI_ST_INS = 4'b0100,
      THI_ST_POST = 4'b1000
   } thi_state_t;
   // Master instruction word
   typedef struct packed {
      logic [7:0] rsv;
      logic [5:0] len_pos;
      logic len_en;
      logic [6:0] hdr_len;
      logic [7:0] hdr_ptr;
      thi_pos_t pos;
   } thi_mi_t;
   typedef struct packed {
      logic [23:0] rsv;
      logic [5:0] ip_off;
      thi_ipsel_t ip_sel;
   } thi_bop_t;
   typedef struct packed {
      logic [29:0] rsv;
      thi_ipsel_t ip_sel;
   } thi_l2t_t;
   typedef struct packed {
      logic [22:0] rsv;
      logic refresh_protocol_byte;
      logic [7:0] new_proto;
   } thi_l3t_t;
   typedef struct packed {
      logic encap_action_flag;
      logic mcast;
      logic [7:0] encap_instruction_pointer;
   } thi_src_t;
   typedef struct packed {
      logic [14:0] pkt_len;
      logic [3:0] port;
      logic l2_miss;
      thi_src_t vlan;
      thi_src_t l2d;
      thi_src_t l2mc;
      thi_src_t nhop;
      thi_src_t eport;
   } thi_req_t;
   typedef struct packed {
      logic [7:0] data;
      logic sop;
      logic eop;
   } thi_byte_t;
endpackage

// ### hdl/thi_tunnel_header_insertion.sv
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "thi_map.svh"
module thi_tunnel_header_insertion #(
   parameter int MI_DEPTH = 16,
   parameter int HD_DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire thi_pkg::thi_byte_t in_byte,
   input wire logic in_valid,
   output logic in_ready,
   input wire thi_pkg::thi_req_t in_req,
   output thi_pkg::thi_byte_t out_byte,
   output logic out_valid,
   input wire logic out_ready
);
   import thi_pkg::*;

   localparam int MIW = $clog2(MI_DEPTH);
   localparam int HDW = $clog2(HD_DEPTH);

   function automatic logic [15:0] ocadd(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0, s[16]};
   endfunction

   function automatic logic [7:0] eff_ptr(input thi_src_t s, input logic mc,
                                          input logic [3:0] port);
      return mc ? s.encap_instruction_pointer + {4'h0, port} : s.encap_instruction_pointer;
   endfunction

   // ****************************************
   // Register storage and APB slave
   // ****************************************
   thi_mi_t mi_tab [MI_DEPTH];
   thi_bop_t bop_tab [MI_DEPTH];
   thi_l2t_t l2_tab [MI_DEPTH];
   thi_l3t_t l3_tab [MI_DEPTH];
   logic [31:0] hdr_mem [HD_DEPTH][16];
   logic ctrl_en;
   logic [15:0] ins_count;
   thi_state_t state;

   wire [7:0] a_page = paddr[15:8];
   wire [5:0] a_idx = paddr[7:2];
   wire a_al = paddr[1:0] == 2'h0;
   wire tab_hit = a_al && a_page <= `THI_L3T_PAGE && 32'(a_idx) < MI_DEPTH;
   wire ctrl_hit = a_al && a_page == `THI_REG_PAGE && paddr[7:0] == `THI_CTRL_OFS;
   wire stat_hit = a_al && a_page == `THI_REG_PAGE && paddr[7:0] == `THI_STAT_OFS;
   // Entry in paddr[11:6], word in paddr[5:2]; the page nibble stays out
   wire [11:0] h_word = {2'h0, paddr[11:2]};
   wire hdr_hit = a_al && paddr[15:12] == `THI_HDR_NIB && 32'(h_word[11:4]) < HD_DEPTH;
   wire addr_ok = tab_hit || ctrl_hit || stat_hit || hdr_hit;
   wire [MIW-1:0] t_i = a_idx[MIW-1:0];
   wire [HDW-1:0] h_e = h_word[HDW+3:4];
   wire [3:0] h_w = h_word[3:0];
   wire setup = psel && !penable && !pready;
   wire wr_go = psel && penable && pready && pwrite && addr_ok;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hdr_hit)
         rd_mux = hdr_mem[h_e][h_w];
      else if (ctrl_hit)
         rd_mux = {31'h0, ctrl_en};
      else if (stat_hit)
         rd_mux = {12'h0, state, ins_count};
      else if (tab_hit) begin
         unique case (a_page[1:0])
            2'h0: rd_mux = mi_tab[t_i];
            2'h1: rd_mux = bop_tab[t_i];
            2'h2: rd_mux = l2_tab[t_i];
            2'h3: rd_mux = l3_tab[t_i];
         endcase
      end
   end

   // Zero-wait answer: pready rises on the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
         pslverr <= setup && !addr_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en <= `THI_CTRL_RST;
         for (int i = 0; i < MI_DEPTH; i++) begin
            mi_tab[i] <= '0;
            bop_tab[i] <= '0;
            l2_tab[i] <= '0;
            l3_tab[i] <= '0;
         end
         for (int e = 0; e < HD_DEPTH; e++)
            for (int w = 0; w < 16; w++)
               hdr_mem[e][w] <= 32'h0;
      end else if (wr_go) begin
         if (ctrl_hit)
            ctrl_en <= pwdata[0];
         if (hdr_hit)
            hdr_mem[h_e][h_w] <= pwdata;
         if (tab_hit) begin
            unique case (a_page[1:0])
               2'h0: mi_tab[t_i] <= thi_mi_t'(pwdata);
               2'h1: bop_tab[t_i] <= thi_bop_t'(pwdata);
               2'h2: l2_tab[t_i] <= thi_l2t_t'(pwdata);
               2'h3: l3_tab[t_i] <= thi_l3t_t'(pwdata);
            endcase
         end
      end
   end

   // ****************************************
   // Two-byte input queue, gives one byte of lookahead
   // ****************************************
   thi_byte_t q [2];
   logic [1:0] qn;
   thi_req_t req_q;
   logic pop;
   wire push = in_valid && in_ready;
   wire [1:0] next_qn = qn + {1'b0, push} - {1'b0, pop};
   wire [1:0] wpos = qn - {1'b0, pop};
   wire have = (qn == 2'd2) || (qn != 2'd0 && q[0].eop);
   wire adv = !out_valid || out_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qn <= 2'd0;
         in_ready <= 1'b0;
         q[0] <= '0;
         q[1] <= '0;
         req_q <= '0;
      end else begin
         qn <= next_qn;
         in_ready <= next_qn < 2'd2;
         if (pop)
            q[0] <= q[1];
         if (push)
            q[wpos[0]] <= in_byte;
         if (push && in_byte.sop)
            req_q <= in_req;
      end
   end

   // ****************************************
   // Instruction pointer selection
   // ****************************************
   wire [3:0] port = req_q.port;
   wire flood = req_q.l2_miss && req_q.vlan.encap_action_flag;
   wire sel_flag = req_q.eport.encap_action_flag || req_q.nhop.encap_action_flag ||
                   req_q.l2mc.encap_action_flag || req_q.l2d.encap_action_flag || flood;
   wire [7:0] sel_ptr =
      req_q.eport.encap_action_flag ? eff_ptr(req_q.eport, 1'b0, port) :
      req_q.nhop.encap_action_flag ? eff_ptr(req_q.nhop, req_q.nhop.mcast, port) :
      req_q.l2mc.encap_action_flag ? eff_ptr(req_q.l2mc, 1'b1, port) :
      req_q.l2d.encap_action_flag ? eff_ptr(req_q.l2d, 1'b0, port) :
      eff_ptr(req_q.vlan, 1'b1, port);
   wire ptr_ok = 32'(sel_ptr) < MI_DEPTH;
   wire [MIW-1:0] ti = sel_ptr[MIW-1:0];
   // Same index into every instruction table
   wire thi_mi_t mi_e = mi_tab[ti];
   wire thi_bop_t bop_e = bop_tab[ti];
   wire thi_l2t_t l2_e = l2_tab[ti];
   wire thi_l3t_t l3_e = l3_tab[ti];
   // No check of the packet's own headers before deciding
   wire go = ctrl_en && sel_flag && ptr_ok && mi_e.pos != THI_POS_RSV &&
             mi_e.hdr_len != 7'd0;

   // ****************************************
   // Per-packet context and parser
   // ****************************************
   thi_mi_t ent;
   thi_ipsel_t ip_sel;
   logic [5:0] ip_off;
   logic refresh;
   logic [7:0] nproto;
   logic [15:0] pkt_len, cnt, l2end, ins_off, old_len, len_q, w8, csum_q;
   logic [1:0] vlans;
   logic l2_known, ins_known, l3v4, l3v6, tail, sop_pend, active;
   logic [5:0] hidx;

   wire [15:0] et = {q[0].data, q[1].data};
   wire is_tpid = et == `THI_TPID_C || et == `THI_TPID_S;
   wire at_l2 = !l2_known && cnt == l2end;
   wire [15:0] ip0 = l2end + `THI_ETYPE_LEN;
   wire [15:0] rel = cnt - ip0;
   wire is_l3 = ent.pos == THI_POS_AFTER_L3 && l2_known;
   wire [15:0] sum_len = et + {9'h0, ent.hdr_len};
   wire [7:0] proto_new = refresh ? nproto : w8[7:0];
   wire [15:0] csum_new = ~ocadd(ocadd(ocadd(~et, ~old_len), len_q),
                                 ocadd(~w8, {w8[15:8], proto_new}));
   wire [15:0] ihl_len = {10'h0, q[0].data[3:0], 2'b00};
   wire ins_now = ins_known && cnt == ins_off;
   wire [6:0] hlen_clamp = (mi_e.hdr_len > `THI_MAX_HDR) ? `THI_MAX_HDR : mi_e.hdr_len;

   // Edits on the preceding L3 header for after-L3 insertion
   logic [7:0] pass_data;
   always_comb begin
      pass_data = q[0].data;
      if (is_l3 && l3v4) begin
         if (rel == `THI_V4_LEN_OFS)
            pass_data = sum_len[15:8];
         else if (rel == `THI_V4_LEN_OFS + 16'd1)
            pass_data = len_q[7:0];
         else if (rel == `THI_V4_PROTO_OFS)
            pass_data = proto_new;
         else if (rel == `THI_V4_CSUM_OFS)
            pass_data = csum_new[15:8];
         else if (rel == `THI_V4_CSUM_OFS + 16'd1)
            pass_data = csum_q[7:0];
      end else if (is_l3 && l3v6) begin
         if (rel == `THI_V6_LEN_OFS)
            pass_data = sum_len[15:8];
         else if (rel == `THI_V6_LEN_OFS + 16'd1)
            pass_data = len_q[7:0];
         else if (rel == `THI_V6_NH_OFS && refresh)
            pass_data = nproto;
      end
   end

   // ****************************************
   // Header image with length and checksum patches
   // ****************************************
   // Frozen during insertion, so this is the original byte count still to come
   wire [15:0] rem = pkt_len - cnt;
   wire [15:0] ip_tot = {9'h0, ent.hdr_len} - {10'h0, ip_off} + rem;
   wire [15:0] len_val = {9'h0, ent.hdr_len} - {10'h0, ent.len_pos} - 16'd2 + rem;
   wire [HDW-1:0] he = ent.hdr_ptr[HDW-1:0];
   logic [7:0] hb [64];
   logic [15:0] ck;
   always_comb begin
      ck = 16'h0;
      for (int k = 0; k < 64; k++)
         hb[k] = hdr_mem[he][k / 4][31 - 8 * (k % 4) -: 8];
      if (ent.len_en) begin
         hb[ent.len_pos] = len_val[15:8];
         hb[6'(ent.len_pos + 6'd1)] = len_val[7:0];
      end
      if (ip_sel == THI_IP_V4) begin
         hb[6'(ip_off + 6'd2)] = ip_tot[15:8];
         hb[6'(ip_off + 6'd3)] = ip_tot[7:0];
         hb[6'(ip_off + 6'd10)] = 8'h00;
         hb[6'(ip_off + 6'd11)] = 8'h00;
         for (int j = 0; j < 20; j += 2)
            ck = ocadd(ck, {hb[6'(ip_off + 6'(j))], hb[6'(ip_off + 6'(j + 1))]});
         hb[6'(ip_off + 6'd10)] = ~ck[15:8];
         hb[6'(ip_off + 6'd11)] = ~ck[7:0];
      end else if (ip_sel == THI_IP_V6) begin
         hb[6'(ip_off + 6'd4)] = 8'((ip_tot - `THI_IPV6_HLEN) >> 8);
         hb[6'(ip_off + 6'd5)] = 8'(ip_tot - `THI_IPV6_HLEN);
      end
   end

   // ****************************************
   // Stream control
   // ****************************************
   wire last_hdr = {1'b0, hidx} == ent.hdr_len - 7'd1;
   always_comb begin
      pop = 1'b0;
      unique case (state)
         THI_ST_IDLE: pop = have && !q[0].sop;
         THI_ST_PRE: pop = have && adv && !ins_now && !(at_l2 && !is_tpid) &&
                           !(at_l2 && vlans == `THI_MAX_VLANS);
         THI_ST_INS: pop = 1'b0;
         THI_ST_POST: pop = have && adv;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= THI_ST_IDLE;
         ent <= '0;
         ip_sel <= THI_IP_NONE;
         ip_off <= 6'h0;
         refresh <= 1'b0;
         nproto <= 8'h0;
         pkt_len <= 16'h0;
         cnt <= 16'h0;
         l2end <= 16'h0;
         ins_off <= 16'h0;
         old_len <= 16'h0;
         len_q <= 16'h0;
         w8 <= 16'h0;
         csum_q <= 16'h0;
         vlans <= 2'd0;
         l2_known <= 1'b0;
         ins_known <= 1'b0;
         l3v4 <= 1'b0;
         l3v6 <= 1'b0;
         tail <= 1'b0;
         sop_pend <= 1'b0;
         active <= 1'b0;
         hidx <= 6'h0;
         ins_count <= 16'h0;
         out_byte <= '0;
         out_valid <= 1'b0;
      end else begin
         if (out_ready)
            out_valid <= 1'b0;
         unique case (state)
            THI_ST_IDLE: begin
               if (have && q[0].sop) begin
                  ent <= mi_e;
                  ent.hdr_len <= hlen_clamp;
                  ip_sel <= (mi_e.pos == THI_POS_BEGIN) ? bop_e.ip_sel : l2_e.ip_sel;
                  ip_off <= (mi_e.pos == THI_POS_BEGIN) ? bop_e.ip_off : `THI_L2_IP_OFS;
                  refresh <= l3_e.refresh_protocol_byte;
                  nproto <= l3_e.new_proto;
                  pkt_len <= {1'b0, req_q.pkt_len};
                  cnt <= 16'h0;
                  l2end <= `THI_ETH_L2_LEN;
                  vlans <= 2'd0;
                  l2_known <= 1'b0;
                  ins_known <= 1'b0;
                  tail <= 1'b0;
                  hidx <= 6'h0;
                  sop_pend <= 1'b1;
                  active <= go;
                  // Packet arrives after VLAN and next-hop edits; this stage runs last
                  if (!go)
                     state <= THI_ST_POST;
                  else if (mi_e.pos == THI_POS_BEGIN)
                     state <= THI_ST_INS;
                  else
                     state <= THI_ST_PRE;
               end
            end
            THI_ST_PRE: begin
               if (have && adv) begin
                  if (ins_now)
                     state <= THI_ST_INS;
                  else if (at_l2 && is_tpid && vlans != `THI_MAX_VLANS) begin
                     l2end <= l2end + `THI_VLAN_LEN;
                     vlans <= vlans + 2'd1;
                  end else if (at_l2) begin
                     l2_known <= 1'b1;
                     l3v4 <= et == `THI_ETYPE_IPV4;
                     l3v6 <= et == `THI_ETYPE_IPV6;
                     if (ent.pos == THI_POS_AFTER_L2 ||
                         (et != `THI_ETYPE_IPV4 && et != `THI_ETYPE_IPV6)) begin
                        ins_known <= 1'b1;
                        ins_off <= (ent.pos == THI_POS_AFTER_L2) ? l2end : ip0;
                     end
                  end
                  if (pop) begin
                     out_valid <= 1'b1;
                     out_byte <= '{data: pass_data, sop: sop_pend, eop: 1'b0};
                     sop_pend <= 1'b0;
                     cnt <= cnt + 16'd1;
                     if (is_l3 && cnt == ip0) begin
                        ins_known <= 1'b1;
                        ins_off <= ip0 + (l3v4 ? ihl_len : `THI_IPV6_HLEN);
                     end
                     if (is_l3 && ((l3v4 && rel == `THI_V4_LEN_OFS) ||
                                   (l3v6 && rel == `THI_V6_LEN_OFS))) begin
                        old_len <= et;
                        len_q <= sum_len;
                     end
                     if (is_l3 && l3v4 && rel == `THI_V4_W8_OFS)
                        w8 <= et;
                     if (is_l3 && l3v4 && rel == `THI_V4_CSUM_OFS)
                        csum_q <= csum_new;
                     // Short packet: header is still appended
                     if (q[0].eop) begin
                        tail <= 1'b1;
                        state <= THI_ST_INS;
                     end
                  end
               end
            end
            THI_ST_INS: begin
               if (adv) begin
                  out_valid <= 1'b1;
                  out_byte <= '{data: hb[hidx], sop: sop_pend, eop: tail && last_hdr};
                  sop_pend <= 1'b0;
                  hidx <= hidx + 6'd1;
                  if (last_hdr) begin
                     state <= tail ? THI_ST_IDLE : THI_ST_POST;
                     if (tail)
                        ins_count <= ins_count + 16'd1;
                  end
               end
            end
            THI_ST_POST: begin
               if (have && adv) begin
                  out_valid <= 1'b1;
                  out_byte <= '{data: q[0].data, sop: sop_pend, eop: q[0].eop};
                  sop_pend <= 1'b0;
                  cnt <= cnt + 16'd1;
                  if (q[0].eop) begin
                     state <= THI_ST_IDLE;
                     if (active)
                        ins_count <= ins_count + 16'd1;
                  end
               end
            end
         endcase
      end
   end
endmodule // thi_tunnel_header_insertion

// ### dv/thi_apb_assertions.sv
`timescale 1ns/1ns
module thi_apb_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire thi_pkg::thi_byte_t out_byte,
   input wire logic out_valid,
   input wire logic out_ready
);
   import thi_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_idle_quiet: assert property (!(psel && !penable) |=> !pready)
      else $error("ready without setup");
   a_ready_width: assert property ($rose(pready) |=> $fell(pready))
      else $error("ready longer than one cycle");
   a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("unaligned access not refused");
   a_ctrl_mapped: assert property (psel && !penable && paddr == 16'h0400 |=> !pslverr)
      else $error("control register refused");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error without ready or with data");
   a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data on a write");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
      else $error("output byte lost under stall");
endmodule // thi_apb_checker
bind thi_tunnel_header_insertion thi_apb_checker u_chk (.pclk, .presetn, .paddr, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .out_byte, .out_valid, .out_ready);

// ### dv/thi_egress_sink.sv
`timescale 1ns/1ns
// ****************************************
// Output port model: collects bytes, may stall
// ****************************************
module thi_egress_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire thi_pkg::thi_byte_t out_byte,
   input wire logic out_valid,
   input wire logic stall,
   output logic out_ready
);
   import thi_pkg::*;
   thi_byte_t got[$];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= stall ? ~out_ready : 1'b1;
         if (out_valid && out_ready) got.push_back(out_byte);
      end
   end
endmodule // thi_egress_sink

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   import thi_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, in_ready;
   logic out_valid, out_ready, stall, er;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pk[$], ex[$];
   thi_byte_t in_byte, out_byte;
   thi_req_t in_req, rq;
   int fail_count = 0;
   int n_tests = 0;
   thi_tunnel_header_insertion dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .in_byte, .in_valid, .in_ready, .in_req,
      .out_byte, .out_valid, .out_ready);
   thi_egress_sink sink (.pclk, .presetn, .out_byte, .out_valid, .stall, .out_ready);
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Sends packet p, then compares the whole output packet with e
   task automatic run(input thi_req_t r, input logic [7:0] p[$], input logic [7:0] e[$]);
      int n;
      sink.got.delete();
      foreach (p[i]) begin
         @(posedge pclk);
         in_valid <= 1'b1; in_req <= r; in_byte <= '{p[i], i == 0, i == p.size() - 1};
         do @(posedge pclk); while (in_ready !== 1'b1);
         in_valid <= 1'b0;
      end
      n = 0;
      while (sink.got.size() < e.size() && n < 600) begin
         @(posedge pclk);
         n++;
      end
      repeat (20) @(posedge pclk);
      chk(sink.got.size(), e.size());
      foreach (e[i]) begin
         chk(sink.got[i], {e[i], i == 0, i == e.size() - 1});
      end
   endtask
   initial begin
      #2000000;
      fail_count++;
      end_of_test();
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0;
      pwdata = 32'h0; in_valid = 1'b0; in_byte = '0; in_req = '0; stall = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 16'h0400, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, 16'h1000, 32'ha1b2c3d4);
      apb(1'b1, 16'h0000, 32'h00001000);
      apb(1'b0, 16'h0000, 32'h0);
      chk(rd, 32'h00001000);
      apb(1'b0, 16'h0802, 32'h0);
      chk(er, 1'b1);
      $display("register test done");
      rq = '0; rq.pkt_len = 15'd6; rq.l2d = '{1'b1, 1'b0, 8'h00};
      pk = {8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
      ex = {8'ha1, 8'hb2, 8'hc3, 8'hd4, pk};
      run(rq, pk, ex);
      $display("begin insertion test done");
      apb(1'b1, 16'h0000, 32'h000a1000);
      ex[2] = 8'h00; ex[3] = 8'h06;
      run(rq, pk, ex);
      $display("length field test done");
      rq.eport = '{1'b1, 1'b0, 8'h01};
      run(rq, pk, pk);
      $display("port priority test done");
      apb(1'b1, 16'h0004, 32'h00001000);
      ex[2] = 8'hc3; ex[3] = 8'hd4;
      rq = '0; rq.pkt_len = 15'd6; rq.port = 4'h1; rq.l2mc = '{1'b1, 1'b1, 8'h00};
      run(rq, pk, ex);
      $display("multicast test done");
      rq = '0; rq.pkt_len = 15'd6; rq.port = 4'h1; rq.l2_miss = 1'b1;
      rq.vlan = '{1'b1, 1'b1, 8'h00};
      run(rq, pk, ex);
      $display("flood test done");
      // Entry 2: after L3, header entry 0, 4 bytes; protocol refresh to 8'h11
      apb(1'b1, 16'h0008, 32'h00001002);
      apb(1'b1, 16'h0308, 32'h00000111);
      pk.delete();
      for (int i = 0; i < 60; i++) pk.push_back(8'(i));
      pk[12] = 8'h86; pk[13] = 8'hdd;
      ex = {pk[0:53], 8'ha1, 8'hb2, 8'hc3, 8'hd4, pk[54:59]};
      ex[19] = 8'h17; ex[20] = 8'h11;
      rq = '0; rq.pkt_len = 15'd60; rq.l2d = '{1'b1, 1'b0, 8'h00};
      rq.nhop = '{1'b1, 1'b0, 8'h02};
      run(rq, pk, ex);
      $display("after L3 test done");
      // Idle state, five packets with a header inserted
      apb(1'b0, 16'h0404, 32'h0);
      chk(rd, 32'h00010005);
      $display("status test done");
      end_of_test();
   end
endmodule // testbench
